// File: t1pm_pkg.sv
// Purpose: Shared constants for the T1 performance monitor counter block.
// Assumes: 100 MHz clk_i, classic Wishbone register access, 32-bit data.
// Notes:   Register offsets are byte addresses of aligned words.
package t1pm_pkg;
  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int unsigned ADR_W          = 8;
  localparam int unsigned DAT_W          = 32;
  localparam logic [7:0]  OFS_ACCESS_PORT = 8'h00;
  localparam logic [7:0]  OFS_ACCESS_DATA = 8'h04;
  localparam logic [7:0]  OFS_CONTROL     = 8'h08;
  localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h0C;
  localparam logic [7:0]  OFS_IRQ_MASK    = 8'h10;

  // Field positions.
  localparam int unsigned IDX_LSB      = 0;
  localparam int unsigned IDX_W        = 4;
  localparam int unsigned LINK_BIT     = 4;
  localparam int unsigned TRIG_BIT     = 0;
  localparam int unsigned AUTO_BIT     = 1;
  localparam int unsigned FMT_LSB      = 2;
  localparam int unsigned FMT_W        = 2;
  localparam int unsigned J1_BIT       = 4;
  localparam int unsigned CTRL_W       = 5;
  localparam int unsigned STAT_W       = 16;
  localparam int unsigned STAT_STRIDE  = 8;

  // Reset values.
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [STAT_W-1:0] STAT_RST = 16'h0000;
  localparam logic [7:0]        BYTE_RST = 8'h00;

  // ----------------------------------------------------------------
  // Framing formats and events
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    T1PM_FMT_SF   = 2'h0,
    T1PM_FMT_ESF  = 2'h1,
    T1PM_FMT_DDM  = 2'h2,
    T1PM_FMT_LOOP = 2'h3
  } t1pm_format_t;

  localparam int unsigned EVT_NUM  = 7;
  localparam int unsigned EVT_LCV  = 0;
  localparam int unsigned EVT_FER  = 1;
  localparam int unsigned EVT_CRC  = 2;
  localparam int unsigned EVT_ALIGNMENT_SHIFT_COUNT = 3;
  localparam int unsigned EVT_OOF  = 4;
  localparam int unsigned EVT_PRBS = 5;
  localparam int unsigned EVT_DDS  = 6;

  // Counter widths.
  localparam int unsigned LCV_W = 16;
  localparam int unsigned FER_W = 12;
  localparam int unsigned CRC_W = 10;
  localparam int unsigned COF_W = 3;
  localparam int unsigned OOF_W = 5;
  localparam int unsigned PRB_W = 16;
  localparam int unsigned DDS_W = 10;

  // Indirect counter indexes.
  localparam logic [3:0] IX_CRC_LO = 4'h0;
  localparam logic [3:0] IX_CRC_HI = 4'h1;
  localparam logic [3:0] IX_FER_LO = 4'h2;
  localparam logic [3:0] IX_FER_HI = 4'h3;
  localparam logic [3:0] IX_ALIGNMENT_SHIFT_COUNT   = 4'h4;
  localparam logic [3:0] IX_OOF    = 4'h5;
  localparam logic [3:0] IX_PRB_LO = 4'h6;
  localparam logic [3:0] IX_PRB_HI = 4'h7;
  localparam logic [3:0] IX_LCV_LO = 4'h8;
  localparam logic [3:0] IX_LCV_HI = 4'h9;
  localparam logic [3:0] IX_DDS_LO = 4'hA;
  localparam logic [3:0] IX_DDS_HI = 4'hB;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned ONE_SECOND_NS     = 1000000000;
  localparam int unsigned ONE_SECOND_CYCLES = ONE_SECOND_NS / CLK_PERIOD_NS;
endpackage : t1pm_pkg

// File: t1pm_sat_counter.sv
// Purpose: Saturating event counter with group clear.
// Assumes: event_i is a one-cycle pulse on clk_i.
// Notes:   A clear loads the coincident event so nothing is dropped.
`timescale 1ns/1ps
module t1pm_sat_counter #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             event_i,
  input  wire logic             enable_i,
  input  wire logic             clear_i,
  output logic      [WIDTH-1:0] count_o,
  output logic                  overflow_o
);
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic             hit;
  logic             at_max;

  // Count qualified events, hold at the top instead of wrapping.
  assign hit        = event_i & enable_i;
  assign at_max     = &count_q;
  assign overflow_o = hit & at_max;
  assign count_d    = clear_i ? {{(WIDTH-1){1'b0}}, hit} :
                      (hit & ~at_max) ? count_q + {{(WIDTH-1){1'b0}}, 1'b1} : count_q;
  assign count_o    = count_q;

  // Counter state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end
endmodule : t1pm_sat_counter

// File: t1pm_sec_tick.sv
// Purpose: Periodic one-cycle tick, once per report period.
// Assumes: CYCLES is at least 2.
// Notes:   Shorten CYCLES in simulation.
`timescale 1ns/1ps
module t1pm_sec_tick #(
  parameter int unsigned CYCLES = 100000000
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      tick_o
);
  localparam int unsigned CW = $clog2(CYCLES);

  logic [CW-1:0] cnt_q;
  logic          last;

  // Wrap at the end of the period and flag that cycle.
  assign last   = (cnt_q == CW'(CYCLES - 1));
  assign tick_o = last;

  // Period counter.
  always_ff @(posedge clk_i) begin
    if (rst_i || last) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end
endmodule : t1pm_sec_tick

// File: t1pm_monitor.sv
// Purpose: Per-link performance counters read through an indirect port.
// Assumes: Event inputs are one-cycle pulses synchronous to clk_i.
// Notes:   Registers sit on a classic Wishbone slave, one word each.
`timescale 1ns/1ps

module t1pm_monitor
  import t1pm_pkg::*;
#(
  parameter int unsigned NUM_LINKS   = 2,
  parameter int unsigned TICK_CYCLES = t1pm_pkg::ONE_SECOND_CYCLES
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [t1pm_pkg::ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [t1pm_pkg::DAT_W-1:0]  wb_dat_i,
  output logic      [t1pm_pkg::DAT_W-1:0]  wb_dat_o,
  output logic                             wb_ack_o,
  output logic                             irq_o,
  input  wire logic [NUM_LINKS-1:0]        line_code_event_i,
  input  wire logic [NUM_LINKS-1:0]        framing_bit_event_i,
  input  wire logic [NUM_LINKS-1:0]        crc6_event_i,
  input  wire logic [NUM_LINKS-1:0]        alignment_shift_event_i,
  input  wire logic [NUM_LINKS-1:0]        sync_loss_event_i,
  input  wire logic [NUM_LINKS-1:0]        prbs_checker_event_i,
  input  wire logic [NUM_LINKS-1:0]        dds_event_i
);
  import t1pm_pkg::*;

  // ----------------------------------------------------------------
  // Decoding functions
  // ----------------------------------------------------------------

  // Picks one byte of a link's counters by indirect index; holes read zero.
  function automatic logic [7:0] sel_byte(input logic [3:0]       idx,
                                          input logic [CRC_W-1:0] crc,
                                          input logic [FER_W-1:0] framing_bit_error_count,
                                          input logic [COF_W-1:0] cof,
                                          input logic [OOF_W-1:0] sync_loss_count,
                                          input logic [PRB_W-1:0] prb,
                                          input logic [LCV_W-1:0] line_code_error_count,
                                          input logic [DDS_W-1:0] dds);
    logic [7:0] b;
    b = BYTE_RST;
    case (idx)
      IX_CRC_LO: b = crc[7:0];
      IX_CRC_HI: b = {6'h00, crc[CRC_W-1:8]};
      IX_FER_LO: b = framing_bit_error_count[7:0];
      IX_FER_HI: b = {4'h0, framing_bit_error_count[FER_W-1:8]};
      IX_ALIGNMENT_SHIFT_COUNT:   b = {5'h00, cof};
      IX_OOF:    b = {3'h0, sync_loss_count};
      IX_PRB_LO: b = prb[7:0];
      IX_PRB_HI: b = prb[PRB_W-1:8];
      IX_LCV_LO: b = line_code_error_count[7:0];
      IX_LCV_HI: b = line_code_error_count[LCV_W-1:8];
      IX_DDS_LO: b = dds[7:0];
      IX_DDS_HI: b = {6'h00, dds[DDS_W-1:8]};
      default:   b = BYTE_RST;
    endcase
    return b;
  endfunction : sel_byte

  // Which counters run for a framing format; the T1-only formats stop in J1.
  function automatic logic [EVT_NUM-1:0] fmt_enables(input t1pm_format_t fmt,
                                                     input logic         j1);
    logic [EVT_NUM-1:0] e;
    e = '0;
    e[EVT_LCV]  = 1'b1;
    e[EVT_FER]  = 1'b1;
    e[EVT_ALIGNMENT_SHIFT_COUNT] = 1'b1;
    e[EVT_OOF]  = 1'b1;
    e[EVT_PRBS] = 1'b1;
    case (fmt)
      T1PM_FMT_SF:   e[EVT_CRC] = 1'b0;
      T1PM_FMT_ESF:  e[EVT_CRC] = 1'b1;
      T1PM_FMT_DDM:  e[EVT_DDS] = 1'b1;
      T1PM_FMT_LOOP: e[EVT_DDS] = 1'b0;
      default:       e = '0;
    endcase
    if (j1 && (fmt == T1PM_FMT_DDM || fmt == T1PM_FMT_LOOP)) begin
      e = '0;
    end
    return e;
  endfunction : fmt_enables

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  logic                ack_q;
  logic [DAT_W-1:0]    rdat_q;
  logic                req;
  logic                wr_fire;
  logic [DAT_W-1:0]    rd_word;
  logic                hit_port;
  logic                hit_data;
  logic                hit_ctrl;
  logic                hit_stat;
  logic                hit_mask;

  // Address decode; unmapped words read zero and writes to them are dropped.
  assign req      = wb_cyc_i & wb_stb_i;
  assign wr_fire  = req & ack_q & wb_we_i;
  assign hit_port = (wb_adr_i == OFS_ACCESS_PORT);
  assign hit_data = (wb_adr_i == OFS_ACCESS_DATA);
  assign hit_ctrl = (wb_adr_i == OFS_CONTROL);
  assign hit_stat = (wb_adr_i == OFS_IRQ_STATUS);
  assign hit_mask = (wb_adr_i == OFS_IRQ_MASK);
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Acknowledge one cycle after the request; ack drops the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // ----------------------------------------------------------------
  // Direct registers
  // ----------------------------------------------------------------
  logic [IDX_W-1:0]       idx_q;
  logic                   link_sel_q;
  logic [CTRL_W-1:0]      ctrl_q;
  logic                   trig_prev_q;
  logic [7:0]             data_q;
  logic [STAT_W-1:0]      stat_q;
  logic [STAT_W-1:0]      stat_d;
  logic [STAT_W-1:0]      mask_q;
  logic [STAT_W-1:0]      stat_set;
  logic [STAT_W-1:0]      stat_clr;
  logic [EVT_NUM-1:0]     run_en;
  logic                   trig_rise;
  logic                   tick;
  logic                   transfer;
  logic [7:0]             link_byte [NUM_LINKS];
  logic [7:0]             sel_data;

  // Selector register: counter index and link select.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_q      <= '0;
      link_sel_q <= 1'b0;
    end else if (wr_fire && hit_port && wb_sel_i[0]) begin
      idx_q      <= wb_dat_i[IDX_LSB +: IDX_W];
      link_sel_q <= wb_dat_i[LINK_BIT];
    end
  end

  // Control register: trigger, periodic enable, format and J1 mode.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_fire && hit_ctrl && wb_sel_i[0]) begin
      ctrl_q <= wb_dat_i[CTRL_W-1:0];
    end
  end

  // Previous trigger level for edge detection.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= ctrl_q[TRIG_BIT];
    end
  end

  // Transfer sources: trigger edge always, period tick only when enabled.
  assign trig_rise = ctrl_q[TRIG_BIT] & ~trig_prev_q;
  assign transfer  = trig_rise | (tick & ctrl_q[AUTO_BIT]);
  assign run_en    = fmt_enables(t1pm_format_t'(ctrl_q[FMT_LSB +: FMT_W]), ctrl_q[J1_BIT]);

  t1pm_sec_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  // Data field takes the selected byte only on a transfer, never on a read.
  assign sel_data = link_byte[link_sel_q];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_q <= BYTE_RST;
    end else if (transfer) begin
      data_q <= sel_data;
    end
  end

  // Sticky flags: write one to clear, a new overflow wins over the clear.
  assign stat_clr = (wr_fire && hit_stat) ?
                    (wb_dat_i[STAT_W-1:0] & {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}}) : '0;
  assign stat_d   = (stat_q & ~stat_clr) | stat_set;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= STAT_RST;
    end else begin
      stat_q <= stat_d;
    end
  end

  // Overflow interrupt enables.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= STAT_RST;
    end else if (wr_fire && hit_mask) begin
      if (wb_sel_i[0]) begin
        mask_q[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        mask_q[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  assign irq_o = |(stat_q & mask_q);

  // Read multiplexer.
  assign rd_word = hit_port ? {{(DAT_W-LINK_BIT-1){1'b0}}, link_sel_q, idx_q} :
                   hit_data ? {{(DAT_W-8){1'b0}}, data_q} :
                   hit_ctrl ? {{(DAT_W-CTRL_W){1'b0}}, ctrl_q} :
                   hit_stat ? {{(DAT_W-STAT_W){1'b0}}, stat_q} :
                   hit_mask ? {{(DAT_W-STAT_W){1'b0}}, mask_q} : '0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= '0;
    end else if (req && !ack_q) begin
      rdat_q <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // Per-link counters
  // ----------------------------------------------------------------
  logic [LCV_W-1:0] lcv_cnt [NUM_LINKS];
  logic [FER_W-1:0] fer_cnt [NUM_LINKS];
  logic [CRC_W-1:0] crc_cnt [NUM_LINKS];
  logic [COF_W-1:0] cof_cnt [NUM_LINKS];
  logic [OOF_W-1:0] oof_cnt [NUM_LINKS];
  logic [PRB_W-1:0] prb_cnt [NUM_LINKS];
  logic [DDS_W-1:0] dds_cnt [NUM_LINKS];

  for (genvar l = 0; l < NUM_LINKS; l++) begin : g_link
    logic               clr;
    logic [EVT_NUM-1:0] ovf;

    // Group clear of the selected link on every transfer.
    assign clr = transfer & (link_sel_q == l[0]);
    assign stat_set[l*STAT_STRIDE +: STAT_STRIDE] = {1'b0, ovf};
    assign link_byte[l] = sel_byte(idx_q, crc_cnt[l], fer_cnt[l], cof_cnt[l],
                                   oof_cnt[l], prb_cnt[l], lcv_cnt[l], dds_cnt[l]);

    t1pm_sat_counter #(.WIDTH(LCV_W)) u_lcv (
      .clk_i(clk_i), .rst_i(rst_i), .event_i(line_code_event_i[l]),
      .enable_i(run_en[EVT_LCV]), .clear_i(clr),
      .count_o(lcv_cnt[l]), .overflow_o(ovf[EVT_LCV]));
    t1pm_sat_counter #(.WIDTH(FER_W)) u_fer (
      .clk_i(clk_i), .rst_i(rst_i), .event_i(framing_bit_event_i[l]),
      .enable_i(run_en[EVT_FER]), .clear_i(clr),
      .count_o(fer_cnt[l]), .overflow_o(ovf[EVT_FER]));
    t1pm_sat_counter #(.WIDTH(CRC_W)) u_crc (
      .clk_i(clk_i), .rst_i(rst_i), .event_i(crc6_event_i[l]),
      .enable_i(run_en[EVT_CRC]), .clear_i(clr),
      .count_o(crc_cnt[l]), .overflow_o(ovf[EVT_CRC]));
    t1pm_sat_counter #(.WIDTH(COF_W)) u_cof (
      .clk_i(clk_i), .rst_i(rst_i), .event_i(alignment_shift_event_i[l]),
      .enable_i(run_en[EVT_ALIGNMENT_SHIFT_COUNT]), .clear_i(clr),
      .count_o(cof_cnt[l]), .overflow_o(ovf[EVT_ALIGNMENT_SHIFT_COUNT]));
    t1pm_sat_counter #(.WIDTH(OOF_W)) u_oof (
      .clk_i(clk_i), .rst_i(rst_i), .event_i(sync_loss_event_i[l]),
      .enable_i(run_en[EVT_OOF]), .clear_i(clr),
      .count_o(oof_cnt[l]), .overflow_o(ovf[EVT_OOF]));
    t1pm_sat_counter #(.WIDTH(PRB_W)) u_prb (
      .clk_i(clk_i), .rst_i(rst_i), .event_i(prbs_checker_event_i[l]),
      .enable_i(run_en[EVT_PRBS]), .clear_i(clr),
      .count_o(prb_cnt[l]), .overflow_o(ovf[EVT_PRBS]));
    t1pm_sat_counter #(.WIDTH(DDS_W)) u_dds (
      .clk_i(clk_i), .rst_i(rst_i), .event_i(dds_event_i[l]),
      .enable_i(run_en[EVT_DDS]), .clear_i(clr),
      .count_o(dds_cnt[l]), .overflow_o(ovf[EVT_DDS]));
  end

  // ----------------------------------------------------------------
  // Checks on link 0
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // A transfer on link 0 with no new line-code event.
  sequence s_quiet_transfer;
    transfer && link_sel_q == 1'b0 && !line_code_event_i[0];
  endsequence

  // Trigger written high while it was low.
  sequence s_trigger_edge;
    !ctrl_q[TRIG_BIT] ##1 ctrl_q[TRIG_BIT];
  endsequence

  chk_flag_on_overflow: assert property (
    g_link[0].ovf[EVT_ALIGNMENT_SHIFT_COUNT] |=> stat_q[EVT_ALIGNMENT_SHIFT_COUNT])
    else $error("alignment change overflow did not set its flag");

  chk_irq_gated_off: assert property (
    (mask_q == '0) |-> !irq_o)
    else $error("interrupt raised with every enable clear");

  chk_irq_flag_mask: assert property (
    (stat_q[EVT_ALIGNMENT_SHIFT_COUNT] && mask_q[EVT_ALIGNMENT_SHIFT_COUNT]) |-> irq_o)
    else $error("enabled flag did not raise the interrupt");

  chk_trigger_copy: assert property (
    s_trigger_edge |-> transfer ##1 (data_q == $past(sel_data)))
    else $error("trigger edge did not load the data field");

  chk_auto_report: assert property (
    (tick && ctrl_q[AUTO_BIT]) |=> (data_q == $past(sel_data)))
    else $error("periodic report did not load the data field");

  chk_data_held: assert property (
    !transfer |=> $stable(data_q))
    else $error("data field changed without a transfer");

  chk_group_clear: assert property (
    s_quiet_transfer ##1 1'b1 |-> lcv_cnt[0] == '0)
    else $error("group clear left the line-code counter nonzero");

  chk_no_event_lost: assert property (
    (transfer && link_sel_q == 1'b0 && line_code_event_i[0] && run_en[EVT_LCV])
      |=> lcv_cnt[0] == LCV_W'(1))
    else $error("event lost during group clear");

  chk_crc_only_esf: assert property (
    (ctrl_q[FMT_LSB +: FMT_W] != T1PM_FMT_ESF && !g_link[0].clr) |=> $stable(crc_cnt[0]))
    else $error("crc counter moved outside ESF");

  chk_dds_j1_off: assert property (
    (ctrl_q[J1_BIT] && !g_link[0].clr) |=> $stable(dds_cnt[0]))
    else $error("dds counter moved in J1 mode");

  chk_saturate_hold: assert property (
    (&cof_cnt[0] && !g_link[0].clr) |=> &cof_cnt[0])
    else $error("alignment change counter wrapped instead of holding");

  chk_alignment_shift_count_step: assert property (
    (alignment_shift_event_i[0] && run_en[EVT_ALIGNMENT_SHIFT_COUNT] && !g_link[0].clr && cof_cnt[0] == 3'h2)
      |=> cof_cnt[0] == 3'h3)
    else $error("alignment change counter did not step");
endmodule : t1pm_monitor

// File: t1pm_tb.sv
// Purpose: Self-checking bench for the T1 performance monitor block.
// Assumes: Classic Wishbone access with one-cycle ack, shortened report tick.
// Notes:   Each transfer clears the whole link, so each round checks one byte.
`timescale 1ns/1ps
module tb;
  import t1pm_pkg::*;
  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  localparam int unsigned TICK = 50;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]        sel = 4'h0;
  logic [ADR_W-1:0]  adr = '0;
  logic [DAT_W-1:0]  wdat = '0, rdat, dat_o;
  logic              ack, irq;
  logic [1:0]        ev [EVT_NUM] = '{default: 2'h0};
  int                num_errors = 0, n_tests = 0, cycles = 0;
  t1pm_monitor #(.NUM_LINKS(2), .TICK_CYCLES(TICK)) t1pm_monitor_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .irq_o(irq), .line_code_event_i(ev[EVT_LCV]),
    .framing_bit_event_i(ev[EVT_FER]), .crc6_event_i(ev[EVT_CRC]),
    .alignment_shift_event_i(ev[EVT_ALIGNMENT_SHIFT_COUNT]), .sync_loss_event_i(ev[EVT_OOF]),
    .prbs_checker_event_i(ev[EVT_PRBS]), .dds_event_i(ev[EVT_DDS]));
  // Clock and a cycle ceiling that cuts a hang short.
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      stop_test();
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // One classic cycle; read data is taken at the edge that sees ack.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rdat = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0; sel <= 4'h0;
  endtask : wb
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Looks at the level once the edge that may have changed it has settled.
  task automatic chk_irq(input logic e);
    @(negedge clk_i);
    chk("irq_o", {31'h0, e}, {31'h0, irq});
  endtask : chk_irq
  // Sends n one-cycle event pulses to one link.
  task automatic pulse(input int e, input int l, input int n);
    repeat (n) begin
      @(posedge clk_i); ev[e][l] <= 1'b1;
      @(posedge clk_i); ev[e][l] <= 1'b0;
    end
  endtask : pulse
  // Selects link and index, raises the trigger, drops it, reads the data field.
  task automatic xfer(input int l, input logic [3:0] ix, input logic [1:0] f,
                      input logic [31:0] e);
    wb(1'b1, OFS_ACCESS_PORT, {27'h0, l[0], ix});
    wb(1'b1, OFS_CONTROL, {28'h0, f, 2'h1});
    wb(1'b1, OFS_CONTROL, {28'h0, f, 2'h0});
    wb(1'b0, OFS_ACCESS_DATA, 32'h0);
    chk("access data", e, rdat);
  endtask : xfer
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values of every register and an unmapped address.
  task automatic t_reset();
    logic [7:0] a [6] = '{OFS_ACCESS_PORT, OFS_ACCESS_DATA, OFS_CONTROL,
                          OFS_IRQ_STATUS, OFS_IRQ_MASK, 8'h20};
    foreach (a[i]) begin
      wb(1'b0, a[i], 32'h0);
      chk("reset read", 32'h0, rdat);
    end
    chk_irq(1'b0);
  endtask : t_reset
  // Every format: crc and dds only where used, group clear after a transfer.
  task automatic t_formats();
    for (int f = 0; f < 4; f++) begin
      wb(1'b1, OFS_CONTROL, {28'h0, f[1:0], 2'h0});
      pulse(EVT_CRC, 0, 2);
      xfer(0, IX_CRC_LO, f[1:0], (f == 1) ? 32'h2 : 32'h0);
      pulse(EVT_DDS, 0, 3);
      xfer(0, IX_DDS_LO, f[1:0], (f == 2) ? 32'h3 : 32'h0);
      pulse(EVT_OOF, 0, 1);
      pulse(EVT_LCV, 0, 2);
      pulse(EVT_FER, 0, 1);
      xfer(0, IX_OOF, f[1:0], 32'h1);
      xfer(0, IX_LCV_LO, f[1:0], 32'h0);
      pulse(EVT_FER, 0, 4);
      xfer(0, IX_FER_LO, f[1:0], 32'h4);
    end
  endtask : t_formats
  // Two-byte counters: the higher index holds the high byte.
  task automatic t_wide();
    pulse(EVT_PRBS, 0, 261);
    xfer(0, IX_PRB_HI, 2'h0, 32'h1);
    pulse(EVT_LCV, 0, 258);
    xfer(0, IX_LCV_LO, 2'h0, 32'h2);
  endtask : t_wide
  // Saturation, sticky flag, mask, interrupt and write-one clear.
  task automatic t_overflow();
    pulse(EVT_ALIGNMENT_SHIFT_COUNT, 0, 8);
    wb(1'b0, OFS_IRQ_STATUS, 32'h0);
    chk("irq status", 32'h8, rdat);
    chk_irq(1'b0);
    wb(1'b1, OFS_IRQ_MASK, 32'h8);
    chk_irq(1'b1);
    xfer(0, IX_ALIGNMENT_SHIFT_COUNT, 2'h0, 32'h7);
    chk_irq(1'b1);
    wb(1'b1, OFS_IRQ_STATUS, 32'h8);
    wb(1'b0, OFS_IRQ_STATUS, 32'h0);
    chk("irq status", 32'h0, rdat);
    chk_irq(1'b0);
  endtask : t_overflow
  // A transfer on one link leaves the other link counting.
  task automatic t_links();
    pulse(EVT_FER, 1, 3);
    xfer(0, IX_FER_LO, 2'h0, 32'h0);
    xfer(1, IX_FER_LO, 2'h0, 32'h3);
  endtask : t_links
  // Periodic report copies the selected counter without a trigger.
  task automatic t_periodic();
    xfer(0, IX_LCV_LO, 2'h0, 32'h0);
    wb(1'b1, OFS_CONTROL, 32'h2);
    pulse(EVT_LCV, 0, 1);
    for (int i = 0; i < 40; i++) begin
      wb(1'b0, OFS_ACCESS_DATA, 32'h0);
      if (rdat !== 32'h0) break;
    end
    chk("periodic data", 32'h1, rdat);
    wb(1'b1, OFS_CONTROL, 32'h0);
  endtask : t_periodic
  // Event on the clear edge lands in the new round; J1 stops the T1-only format.
  task automatic t_edges();
    xfer(0, IX_LCV_LO, 2'h0, 32'h0);
    pulse(EVT_LCV, 0, 2);
    wb(1'b1, OFS_CONTROL, 32'h1);
    ev[EVT_LCV][0] <= 1'b1;
    @(posedge clk_i) ev[EVT_LCV][0] <= 1'b0;
    wb(1'b1, OFS_CONTROL, 32'h0);
    wb(1'b0, OFS_ACCESS_DATA, 32'h0);
    chk("access data", 32'h2, rdat);
    xfer(0, IX_LCV_LO, 2'h0, 32'h1);
    wb(1'b1, OFS_CONTROL, 32'h18);
    pulse(EVT_DDS, 0, 2);
    xfer(0, IX_DDS_LO, 2'h2, 32'h0);
  endtask : t_edges
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_formats();
    t_wide();
    t_overflow();
    t_links();
    t_periodic();
    t_edges();
    stop_test();
  end
endmodule : tb
